// ===== src/dtrc_top.sv
// Summary of operation
// - Idle bit set: insert idle cycle when normal access follows a DRAM read.
// - Idle bit sits at bit 15 and also covers SDRAM accesses.
// - Precharge field 00..11 gives 1..4 precharge states, access and refresh.
// - Row-to-column field inserts 0..3 waits between row and column strobe.
// - Write-latency-skip drops the latency control cycle on SDRAM writes.
// - Clock-suspend enable extends read data in single-address DMA transfers.
// - Read-extension field adds 1..4 states, only while suspend is enabled.
// - Compare-match flag sets when refresh counter equals compare constant.
// - Refresh off: flag cleared by read as one then write zero.
// - Refresh on: flag cleared automatically on each CBR refresh.
// - Match interrupt enable with flag set raises the match interrupt.
// - Refresh on forces match interrupt enable to zero, writes ignored.
// - Column-to-row refresh field inserts 0..3 waits in a refresh cycle.
// - Clock select halts counter at 000, else divides by 2 up to 4096.
// - Refresh enable performs refresh; otherwise timer is an interval timer.
// - Parallel bit: 0 lets accesses outside SDRAM space run beside refresh, 1 refresh alone.
//
// Decided for this implementation: the register addresses and the strobed register port.
`include "dtrc_params.svh"

module dtrc_top
    import dtrc_pkg::*;
(
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Register port.
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    // Access request from the bus arbiter.
    input wire dtrc_access_s i_access,
    input wire logic i_normal_next,
    input wire logic i_sdram_space,
    // Sequencer phase and status.
    output dtrc_phase_s o_phase,
    output logic o_busy,
    output logic o_access_blocked,
    output logic o_refresh_req,
    output logic o_compare_match_interrupt,
    output logic o_irq
);

    logic [15:0] access_timing_ff;
    logic [15:0] refresh_ctrl_ff;
    logic [15:0] refresh_counter_ff;
    logic [15:0] refresh_compare_constant_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_mask_ff;
    logic [15:0] rdata_ff;
    logic flag_seen_ff;
    logic [11:0] prescale_ff;
    logic refresh_pend_ff;
    logic refresh_req_ff;
    dtrc_state_e state_ff;
    logic [1:0] wait_ff;
    logic [2:0] ext_ff;
    logic cur_write_ff;
    logic cur_sdram_ff;
    logic cur_refresh_ff;
    logic cur_read_ff;
    dtrc_phase_s phase_ff;

    function automatic logic [11:0] div_mask(input logic [2:0] sel);
        logic [11:0] m;
        m = 12'h000;
        unique case (sel)
            3'b001: m = 12'h001;
            3'b010: m = 12'h007;
            3'b011: m = 12'h01f;
            3'b100: m = 12'h07f;
            3'b101: m = 12'h1ff;
            3'b110: m = 12'h7ff;
            3'b111: m = 12'hfff;
            default: m = 12'h000;
        endcase
        return m;
    endfunction : div_mask

    // Register decode.
    wire wr_at = i_reg_wr && (i_reg_addr == `DTRC_ADDR_ACCESS_TIMING);
    wire wr_rc = i_reg_wr && (i_reg_addr == `DTRC_ADDR_REFRESH_CTRL);
    wire wr_cnt = i_reg_wr && (i_reg_addr == `DTRC_ADDR_REFRESH_COUNT);
    wire wr_const = i_reg_wr && (i_reg_addr == `DTRC_ADDR_REFRESH_CONST);
    wire wr_ist = i_reg_wr && (i_reg_addr == `DTRC_ADDR_IRQ_STATUS);
    wire wr_imask = i_reg_wr && (i_reg_addr == `DTRC_ADDR_IRQ_MASK);
    wire rd_rc = i_reg_rd && (i_reg_addr == `DTRC_ADDR_REFRESH_CTRL);

    // Field views.
    wire refresh_on = refresh_ctrl_ff[`DTRC_RC_REFRESH_EN];
    wire match_flag = refresh_ctrl_ff[`DTRC_RC_MATCH_FLAG];
    wire [2:0] clk_sel = refresh_ctrl_ff[`DTRC_RC_CLK_SEL_HI:`DTRC_RC_CLK_SEL_LO];
    wire [1:0] precharge_sel =
        access_timing_ff[`DTRC_AT_PRECHARGE_HI:`DTRC_AT_PRECHARGE_LO];
    wire [1:0] row_col_sel = access_timing_ff[`DTRC_AT_ROW_COL_HI:`DTRC_AT_ROW_COL_LO];
    wire [1:0] col_row_sel =
        refresh_ctrl_ff[`DTRC_RC_COL_ROW_HI:`DTRC_RC_COL_ROW_LO];
    wire [1:0] read_ext_sel = access_timing_ff[`DTRC_AT_READ_EXT_HI:`DTRC_AT_READ_EXT_LO];
    wire suspend_en = access_timing_ff[`DTRC_AT_SUSPEND_EN];
    wire idle_insert = access_timing_ff[`DTRC_AT_IDLE_INSERT];
    wire write_skip = access_timing_ff[`DTRC_AT_WRITE_SKIP];
    wire parallel_refresh_select = refresh_ctrl_ff[`DTRC_RC_PARALLEL];

    // Refresh timer.
    wire [11:0] tick_mask = div_mask(clk_sel);
    wire tick = (clk_sel != 3'b000) && ((prescale_ff & tick_mask) == tick_mask);
    wire match_now = tick &&
        ((refresh_counter_ff + 16'h0001) == refresh_compare_constant_ff);
    wire [15:0] nxt_counter = wr_cnt ? i_reg_wdata
        : (match_now && refresh_on) ? 16'h0000
        : tick ? refresh_counter_ff + 16'h0001 : refresh_counter_ff;
    wire start_refresh = refresh_pend_ff && (state_ff == DTRC_IDLE);
    // A flag is only cleared by zero when software has seen it as one first.
    wire sw_clear = wr_rc && !i_reg_wdata[`DTRC_RC_MATCH_FLAG] &&
        flag_seen_ff && !refresh_on;
    wire hw_clear = start_refresh && refresh_on;
    wire nxt_flag = match_now || (match_flag && !sw_clear && !hw_clear);
    wire nxt_refresh_on = wr_rc ? i_reg_wdata[`DTRC_RC_REFRESH_EN] : refresh_on;
    wire nxt_ie = nxt_refresh_on ? 1'b0
        : (wr_rc ? i_reg_wdata[`DTRC_RC_MATCH_IE] : refresh_ctrl_ff[`DTRC_RC_MATCH_IE]);
    wire [15:0] nxt_rc_body = wr_rc ? i_reg_wdata : refresh_ctrl_ff;
    wire [15:0] nxt_refresh_ctrl = {nxt_flag, nxt_ie, nxt_rc_body[13:0]};
    wire [1:0] ev = {start_refresh && refresh_on, match_now};
    wire [1:0] nxt_irq_status = ev | (irq_status_ff & ~(wr_ist ? i_reg_wdata[1:0] : 2'b00));

    // Sequencer.
    wire acc_go = i_access.valid && (state_ff == DTRC_IDLE) && !refresh_pend_ff;
    wire nxt_refresh_pend = (match_now && refresh_on) ||
        (refresh_pend_ff && !start_refresh);
    wire [1:0] prech_wait = precharge_sel;
    wire latency_cycle_kept = !(cur_write_ff && cur_sdram_ff && write_skip);
    wire use_suspend = suspend_en && i_access.single_dma &&
        i_access.sdram && !i_access.write;
    logic suspend_ff;
    dtrc_state_e nxt_state;
    logic [1:0] nxt_wait;
    logic [2:0] nxt_ext;

    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        nxt_ext = ext_ff;
        unique case (state_ff)
            DTRC_IDLE: begin
                if (start_refresh) begin
                    nxt_state = DTRC_COL;
                    nxt_wait = col_row_sel;
                end else if (acc_go) begin
                    nxt_state = DTRC_ROW;
                end
            end
            DTRC_ROW: begin
                if (cur_refresh_ff) begin
                    nxt_state = DTRC_PRECH;
                    nxt_wait = prech_wait;
                end else if (row_col_sel != 2'b00) begin
                    nxt_state = DTRC_RCWAIT;
                    nxt_wait = row_col_sel - 2'b01;
                end else begin
                    nxt_state = DTRC_COL;
                end
            end
            DTRC_RCWAIT: begin
                if (wait_ff == 2'b00) begin
                    nxt_state = cur_refresh_ff ? DTRC_ROW : DTRC_COL;
                end else begin
                    nxt_wait = wait_ff - 2'b01;
                end
            end
            DTRC_COL: begin
                if (cur_refresh_ff) begin
                    if (wait_ff != 2'b00) begin
                        nxt_state = DTRC_RCWAIT;
                        nxt_wait = wait_ff - 2'b01;
                    end else begin
                        nxt_state = DTRC_ROW;
                    end
                end else if (suspend_ff) begin
                    nxt_state = DTRC_EXT;
                    nxt_ext = {1'b0, read_ext_sel};
                end else if (idle_insert && (cur_read_ff || cur_sdram_ff) && i_normal_next) begin
                    nxt_state = DTRC_IDLECYC;
                end else begin
                    nxt_state = DTRC_PRECH;
                    nxt_wait = prech_wait;
                end
            end
            DTRC_EXT: begin
                if (ext_ff == 3'b000) begin
                    nxt_state = (idle_insert && i_normal_next) ?
                        DTRC_IDLECYC : DTRC_PRECH;
                    nxt_wait = prech_wait;
                end else begin
                    nxt_ext = ext_ff - 3'b001;
                end
            end
            DTRC_IDLECYC: begin
                nxt_state = DTRC_PRECH;
                nxt_wait = prech_wait;
            end
            DTRC_PRECH: begin
                if (wait_ff == 2'b00) begin
                    nxt_state = DTRC_IDLE;
                end else begin
                    nxt_wait = wait_ff - 2'b01;
                end
            end
            default: nxt_state = DTRC_IDLE;
        endcase
    end

    dtrc_phase_s nxt_phase;
    always_comb begin
        nxt_phase = '0;
        nxt_phase.row_strobe = (nxt_state == DTRC_ROW);
        nxt_phase.col_strobe = (nxt_state == DTRC_COL);
        nxt_phase.clock_suspend = (nxt_state == DTRC_EXT);
        nxt_phase.latency_cycle = (nxt_state == DTRC_COL) && cur_sdram_ff && latency_cycle_kept;
        nxt_phase.idle_cycle = (nxt_state == DTRC_IDLECYC);
        nxt_phase.precharge = (nxt_state == DTRC_PRECH);
        nxt_phase.refresh = (nxt_state != DTRC_IDLE) && (start_refresh || cur_refresh_ff);
        nxt_phase.done = (state_ff == DTRC_PRECH) && (wait_ff == 2'b00);
    end

    // Parallel refresh lets other external accesses outside SDRAM space proceed beside the CBR cycle.
    assign o_access_blocked = (cur_refresh_ff && (state_ff != DTRC_IDLE)) &&
        (parallel_refresh_select || i_sdram_space);
    assign o_busy = (state_ff != DTRC_IDLE);
    assign o_phase = phase_ff;
    assign o_refresh_req = refresh_req_ff;
    assign o_compare_match_interrupt =
        match_flag && refresh_ctrl_ff[`DTRC_RC_MATCH_IE];
    assign o_irq = |(irq_status_ff & irq_mask_ff);
    assign o_reg_rdata = rdata_ff;

    wire [15:0] rd_mux =
        (i_reg_addr == `DTRC_ADDR_ACCESS_TIMING) ? access_timing_ff :
        (i_reg_addr == `DTRC_ADDR_REFRESH_CTRL) ? refresh_ctrl_ff :
        (i_reg_addr == `DTRC_ADDR_REFRESH_COUNT) ? refresh_counter_ff :
        (i_reg_addr == `DTRC_ADDR_REFRESH_CONST) ? refresh_compare_constant_ff :
        (i_reg_addr == `DTRC_ADDR_IRQ_STATUS) ? {14'h0000, irq_status_ff} :
        (i_reg_addr == `DTRC_ADDR_IRQ_MASK) ? {14'h0000, irq_mask_ff} : 16'h0000;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            access_timing_ff <= `DTRC_RST_ACCESS_TIMING;
            refresh_ctrl_ff <= `DTRC_RST_REFRESH_CTRL;
            refresh_counter_ff <= 16'h0000;
            refresh_compare_constant_ff <= `DTRC_RST_REFRESH_CONST;
            irq_status_ff <= 2'b00;
            irq_mask_ff <= 2'b00;
            rdata_ff <= 16'h0000;
            flag_seen_ff <= 1'b0;
            prescale_ff <= 12'h000;
        end else begin
            access_timing_ff <= wr_at ? i_reg_wdata : access_timing_ff;
            refresh_ctrl_ff <= nxt_refresh_ctrl;
            refresh_counter_ff <= nxt_counter;
            refresh_compare_constant_ff <= wr_const ? i_reg_wdata : refresh_compare_constant_ff;
            irq_status_ff <= nxt_irq_status;
            irq_mask_ff <= wr_imask ? i_reg_wdata[1:0] : irq_mask_ff;
            rdata_ff <= i_reg_rd ? rd_mux : 16'h0000;
            flag_seen_ff <= rd_rc ? match_flag : (wr_rc ? 1'b0 : flag_seen_ff);
            prescale_ff <= (clk_sel == 3'b000) ? 12'h000 : prescale_ff + 12'h001;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= DTRC_IDLE;
            wait_ff <= 2'b00;
            ext_ff <= 3'b000;
            cur_write_ff <= 1'b0;
            cur_sdram_ff <= 1'b0;
            cur_refresh_ff <= 1'b0;
            cur_read_ff <= 1'b0;
            suspend_ff <= 1'b0;
            refresh_pend_ff <= 1'b0;
            refresh_req_ff <= 1'b0;
            phase_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            ext_ff <= nxt_ext;
            phase_ff <= nxt_phase;
            refresh_pend_ff <= nxt_refresh_pend;
            refresh_req_ff <= match_now && refresh_on;
            if (start_refresh) begin
                cur_refresh_ff <= 1'b1;
                cur_read_ff <= 1'b0;
                cur_write_ff <= 1'b0;
                cur_sdram_ff <= 1'b0;
                suspend_ff <= 1'b0;
            end else if (acc_go) begin
                cur_refresh_ff <= 1'b0;
                cur_read_ff <= !i_access.write;
                cur_write_ff <= i_access.write;
                cur_sdram_ff <= i_access.sdram;
                suspend_ff <= use_suspend;
            end
        end
    end

endmodule : dtrc_top

// ===== src/dtrc_params.svh
`ifndef DTRC_PARAMS_SVH
`define DTRC_PARAMS_SVH

// Register byte addresses on the plain register port.
`define DTRC_ADDR_ACCESS_TIMING 8'h00
`define DTRC_ADDR_REFRESH_CTRL 8'h04
`define DTRC_ADDR_REFRESH_COUNT 8'h08
`define DTRC_ADDR_REFRESH_CONST 8'h0c
`define DTRC_ADDR_IRQ_STATUS 8'h10
`define DTRC_ADDR_IRQ_MASK 8'h14

// Access timing register fields.
`define DTRC_AT_IDLE_INSERT 15
`define DTRC_AT_PRECHARGE_HI 13
`define DTRC_AT_PRECHARGE_LO 12
`define DTRC_AT_WRITE_SKIP 11
`define DTRC_AT_ROW_COL_HI 9
`define DTRC_AT_ROW_COL_LO 8
`define DTRC_AT_SUSPEND_EN 3
`define DTRC_AT_READ_EXT_HI 1
`define DTRC_AT_READ_EXT_LO 0

// Refresh control register fields.
`define DTRC_RC_MATCH_FLAG 15
`define DTRC_RC_MATCH_IE 14
`define DTRC_RC_COL_ROW_HI 13
`define DTRC_RC_COL_ROW_LO 12
`define DTRC_RC_CLK_SEL_HI 10
`define DTRC_RC_CLK_SEL_LO 8
`define DTRC_RC_REFRESH_EN 7
`define DTRC_RC_PARALLEL 6

// Reset values.
`define DTRC_RST_ACCESS_TIMING 16'h0000
`define DTRC_RST_REFRESH_CTRL 16'h0000
`define DTRC_RST_REFRESH_CONST 16'hffff

// Interrupt status bits.
`define DTRC_IRQ_MATCH 0
`define DTRC_IRQ_REFRESH 1

// Longest refresh clock divider.
`define DTRC_DIV_MAX 4096

`endif

// ===== src/dtrc_pkg.sv
package dtrc_pkg;

    typedef enum logic [2:0] {
        DTRC_IDLE = 3'b000,
        DTRC_ROW = 3'b001,
        DTRC_RCWAIT = 3'b010,
        DTRC_COL = 3'b011,
        DTRC_EXT = 3'b100,
        DTRC_IDLECYC = 3'b101,
        DTRC_PRECH = 3'b110
    } dtrc_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic sdram;
        logic single_dma;
    } dtrc_access_s;

    typedef struct packed {
        logic row_strobe;
        logic col_strobe;
        logic clock_suspend;
        logic latency_cycle;
        logic idle_cycle;
        logic precharge;
        logic refresh;
        logic done;
    } dtrc_phase_s;

endpackage : dtrc_pkg

// ===== tb/dtrc_dram_model.sv
module dtrc_dram_model
    import dtrc_pkg::*;
(
    // Clock, reset and clear between transfers.
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_clear,
    // Strobes as the memory sees them.
    input wire dtrc_phase_s i_phase,
    // Cycles of precharge, suspend, idle, latency, row-to-col and col-to-row.
    output logic [7:0] o_cnt [6]
);
    timeunit 1ns;
    timeprecision 1ns;

    logic row_seen_ff;
    logic col_seen_ff;
    logic [5:0] hit;
    wire logic row_any = row_seen_ff | i_phase.row_strobe;
    wire logic col_any = col_seen_ff | i_phase.col_strobe;

    // A chip latches on strobe edges, so gaps are timed from the first strobe seen.
    assign hit = {col_any && !row_any, row_any && !col_any, i_phase.latency_cycle,
                  i_phase.idle_cycle, i_phase.clock_suspend, i_phase.precharge};

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b || i_clear) begin
            row_seen_ff <= 1'b0;
            col_seen_ff <= 1'b0;
            o_cnt <= '{default: 8'h00};
        end else begin
            row_seen_ff <= row_any;
            col_seen_ff <= col_any;
            for (int i = 0; i < 6; i++) begin
                o_cnt[i] <= o_cnt[i] + {7'h00, hit[i]};
            end
        end
    end
endmodule : dtrc_dram_model

// ===== tb/dtrc_top_asserts.sv
`include "dtrc_params.svh"

module dtrc_top_asserts
    import dtrc_pkg::*;
(
    // Clock, reset and register port.
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    // Sequencer and refresh outputs.
    input wire dtrc_phase_s o_phase,
    input wire logic o_access_blocked,
    input wire logic o_refresh_req,
    input wire logic o_compare_match_interrupt
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_ctrl_read;
        i_reg_rd && i_reg_addr == `DTRC_ADDR_REFRESH_CTRL ##1 1'b1;
    endsequence
    sequence s_refresh_soon;
        ##[0:40] o_phase.refresh;
    endsequence

    cmi_from_regs_a: assert property (
        s_ctrl_read |-> (o_reg_rdata[15] && o_reg_rdata[14]) == $past(o_compare_match_interrupt))
        else $error("match interrupt disagrees with flag and enable");
    enable_forced_a: assert property (
        s_ctrl_read |-> !(o_reg_rdata[7] && o_reg_rdata[14]))
        else $error("match enable readable as one while refresh on");
    req_single_a: assert property (o_refresh_req |=> !o_refresh_req)
        else $error("refresh request longer than one cycle");
    req_runs_a: assert property (o_refresh_req |=> s_refresh_soon)
        else $error("refresh request not followed by a refresh cycle");
    pre_len_a: assert property (o_phase.precharge [*4] |=> !o_phase.precharge)
        else $error("precharge longer than four states");
    ext_len_a: assert property (
        o_phase.clock_suspend [*4] |=> !o_phase.clock_suspend)
        else $error("read extension longer than four states");
    idle_once_a: assert property (o_phase.idle_cycle |=> !o_phase.idle_cycle)
        else $error("idle cycle longer than one state");
    blocked_refresh_a: assert property ($rose(o_access_blocked) |-> s_refresh_soon)
        else $error("accesses blocked without a refresh");
endmodule : dtrc_top_asserts

bind dtrc_top dtrc_top_asserts i_dtrc_top_asserts (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_phase(o_phase), .o_access_blocked(o_access_blocked),
    .o_refresh_req(o_refresh_req), .o_compare_match_interrupt(o_compare_match_interrupt)
);

// ===== tb/dtrc_top_tb.sv
module dtrc_top_tb
    import dtrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_normal_next = 1'b0, i_sdram_space = 1'b0;
    logic clr = 1'b0;
    dtrc_access_s i_access = '0;
    dtrc_access_s acc;
    dtrc_phase_s o_phase;
    logic [15:0] o_reg_rdata, d, at;
    logic o_busy, o_access_blocked, o_refresh_req, o_compare_match_interrupt, o_irq, nn;
    logic [7:0] cnt [6];
    logic [7:0] adr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 44;
    int n_blk = 0;
    int n;

    initial forever #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (o_access_blocked) n_blk++;

    dtrc_top i_dtrc_top (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_access(i_access), .i_normal_next(i_normal_next),
        .i_sdram_space(i_sdram_space), .o_phase(o_phase), .o_busy(o_busy),
        .o_access_blocked(o_access_blocked), .o_refresh_req(o_refresh_req),
        .o_compare_match_interrupt(o_compare_match_interrupt), .o_irq(o_irq)
    );
    dtrc_dram_model i_dtrc_dram_model (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_clear(clr), .i_phase(o_phase), .o_cnt(cnt)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= v;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        #1 v = o_reg_rdata;
    endtask : rd

    task automatic clear_model;
        @(posedge i_sys_clk);
        clr <= 1'b1;
        @(posedge i_sys_clk);
        clr <= 1'b0;
        n_blk = 0;
    endtask : clear_model

    function automatic logic sig(input int k);
        case (k)
            0: return o_compare_match_interrupt;
            1: return o_refresh_req;
            2: return o_phase.done;
            3: return o_phase.refresh;
            4: return !o_phase.refresh;
            default: return o_busy;
        endcase
    endfunction : sig

    // Bounded wait, so a dead handshake costs one mismatch rather than the whole run.
    task automatic wait_for(input int k, input int lim);
        n = 0;
        #1;
        while (sig(k) !== 1'b1 && n < lim) begin
            @(posedge i_sys_clk);
            #1 n++;
        end
        if (n >= lim) chk(16'h0000, 16'h0001, "wait timed out");
    endtask : wait_for

    function automatic int f_div(input int s);
        return (s == 7) ? 4096 : 1 << (2 * s - 1);
    endfunction : f_div

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (40000) @(posedge i_sys_clk);
        n_mismatch++;
        $display("unexpected at %0t: run did not finish", $time);
        complete_run;
    end

    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        wr(8'h20, 16'hffff);
        for (int i = 0; i < 7; i++) begin
            rd(adr[i], d);
            chk(d, (i == 3) ? 16'hffff : 16'h0000, "reset or unmapped value");
        end
        for (int i = 0; i < 4; i++) begin
            at = 16'($random(seed)) & ((i < 2) ? 16'hbb0b : 16'h7740);
            wr((i < 2) ? 8'h00 : 8'h04, at);
            rd((i < 2) ? 8'h00 : 8'h04, d);
            chk(d, at, "register readback");
        end
        // Halt the timer left running by the readback so each match is timed from zero.
        wr(8'h04, 16'h0000);
        wr(8'h0c, 16'h0002);
        for (int s = 1; s < 8; s++) begin
            wr(8'h08, 16'h0000);
            wr(8'h04, 16'h4000 | 16'(s << 8));
            wait_for(0, 3 * f_div(s) + 20);
            chk({15'h0, n >= f_div(s) && n <= 2 * f_div(s) + 6}, 16'h0001, "match time");
            rd(8'h04, d);
            chk(d & 16'hc000, 16'hc000, "flag and enable after match");
            if (s == 1) begin
                wr(8'h14, 16'h0001);
                #1 chk({15'h0, o_irq}, 16'h0001, "unmasked event interrupt");
                wr(8'h10, 16'h0001);
                #1 chk({15'h0, o_irq}, 16'h0000, "status cleared by one");
                wr(8'h04, 16'hc000);
                wr(8'h04, 16'h4000);
                rd(8'h04, d);
                chk(d & 16'h8000, 16'h8000, "flag kept without fresh read");
            end
            wr(8'h04, 16'h4000);
            rd(8'h04, d);
            chk(d, 16'h4000, "flag cleared after read then write");
            chk({15'h0, o_compare_match_interrupt}, 16'h0000, "interrupt drops");
        end
        wr(8'h08, 16'h0000);
        repeat (40) @(posedge i_sys_clk);
        rd(8'h08, d);
        chk(d, 16'h0000, "counter halted");
        for (int w = 0; w < 4; w++) begin
            i_sdram_space <= w[1];
            wr(8'h00, 16'(w << 12));
            wr(8'h08, 16'h0000);
            wr(8'h0c, 16'h0004);
            clear_model;
            wr(8'h04, 16'h4280 | 16'(w << 12) | 16'((w & 1) << 6));
            wait_for(1, 100);
            wait_for(3, 40);
            wait_for(4, 40);
            rd(8'h04, d);
            chk(d & 16'hc000, 16'h0000, "flag cleared, enable held low");
            rd(8'h08, d);
            chk({15'h0, d < 16'h0004}, 16'h0001, "counter restarted");
            chk({8'h0, cnt[5]}, 16'(w + 1), "column to row refresh wait");
            chk({8'h0, cnt[0]}, 16'(w + 1), "refresh precharge");
            chk({15'h0, n_blk != 0}, {15'h0, w != 0}, "refresh alone blocks");
            wr(8'h04, 16'h0000);
        end
        for (int k = 0; k < 16; k++) begin
            at = (k == 0) ? 16'hbb0b : 16'($random(seed)) & 16'hbb0b;
            acc = (k == 0) ? 4'hb : {1'b1, 3'($random(seed))};
            nn = (k == 0) ? 1'b1 : 1'($random(seed));
            wr(8'h00, at);
            clear_model;
            i_access <= acc;
            i_normal_next <= nn;
            i_sdram_space <= 1'($random(seed));
            wait_for(5, 4);
            @(posedge i_sys_clk);
            i_access <= '0;
            wait_for(2, 40);
            @(posedge i_sys_clk);
            #1 chk({8'h0, cnt[0]}, 16'(at[13:12]) + 16'h1, "precharge states");
            chk({8'h0, cnt[4]}, 16'(at[9:8]) + 16'h1, "row to column wait");
            chk({8'h0, cnt[1]}, (at[3] && acc.sdram && acc.single_dma && !acc.write) ?
                16'(at[1:0]) + 16'h1 : 16'h0000, "read extension");
            chk({8'h0, cnt[2]}, {15'h0, at[15] && nn && (acc.sdram || !acc.write)},
                "idle insertion");
            chk({15'h0, cnt[3] != 0}, {15'h0, acc.sdram && !(acc.write && at[11])},
                "latency control cycle");
        end
        complete_run;
    end
endmodule : dtrc_top_tb
